// file: verilog/urc_consts.svh
// constants for the receive channel: offsets, fields, resets, timing
`ifndef URC_CONSTS_SVH
`define URC_CONSTS_SVH
`define URC_A_RHR 8'h00
`define URC_A_IER 8'h04
`define URC_A_IIR 8'h08
`define URC_A_FCR 8'h0C
`define URC_A_LCR 8'h10
`define URC_A_MCR 8'h14
`define URC_A_LSR 8'h18
`define URC_A_DLL 8'h1C
`define URC_A_DLH 8'h20
`define URC_A_EFR 8'h24
`define URC_IER_RX 0
`define URC_IER_RTS 6
`define URC_FCR_EN 0
`define URC_FCR_CLR 1
`define URC_FCR_DMA 3
`define URC_FCR_TRG 6
`define URC_MCR_RTS 1
`define URC_EFR_ARTS 6
`define URC_LCR_PEN 3
`define URC_LCR_EPS 4
`define URC_LCR_STB 2
`define URC_DIV_RST 16'h0001
`define URC_LCR_RST 8'h03
`define URC_OVS 16
`define URC_MID 4'h7
`define URC_LAST 4'hF
`define URC_TO_CHARS 4
`define URC_TO_BITS 12
`define URC_POR_CYCLES 8388608
`define URC_TRG16 {8'h0E, 8'h08, 8'h04, 8'h01}
`define URC_OFF16 {8'h0E, 8'h0E, 8'h08, 8'h02}
`define URC_ON16 {8'h08, 8'h04, 8'h01, 8'h00}
`define URC_TRG64 {8'h3C, 8'h38, 8'h10, 8'h08}
`define URC_OFF64 {8'h3C, 8'h3C, 8'h38, 8'h10}
`define URC_ON64 {8'h38, 8'h10, 8'h08, 8'h00}
`endif

// file: verilog/urc_pkg.sv
// types shared by the receive channel
`default_nettype none
package urc_pkg;
  typedef enum logic [2:0]
  {
    st_idle  = 3'b000,
    st_start = 3'b001,
    st_data  = 3'b010,
    st_par   = 3'b011,
    st_stop  = 3'b100
  } urc_rx_state_type;
endpackage
`default_nettype wire

// file: verilog/urc_receive_channel.sv
// receive channel: baud divider, receiver, fifo, timeout, dma, auto rts
`default_nettype none
`include "urc_consts.svh"
module urc_receive_channel
#(
  parameter int          DEPTH      = 16,
  parameter int unsigned POR_CYCLES = `URC_POR_CYCLES
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // pins
  input  wire logic        serial_in,
  input  wire logic        external_reset,
  output logic             request_to_send_n,
  output logic             receive_dma_request_n,
  output logic             baud_clock_output,
  output logic             interrupt_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);

  // pin synchronisers, level moves once stages 2 and 3 agree
  logic [2:0] rx_sync_ff;
  logic [2:0] xr_sync_ff;
  logic       rx_lvl_ff;
  logic       rx_lvl_d_ff;
  logic       xr_lvl_ff;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rx_sync_ff  <= 3'h7;
      xr_sync_ff  <= 3'h0;
      rx_lvl_ff   <= 1'b1;
      rx_lvl_d_ff <= 1'b1;
      xr_lvl_ff   <= 1'b0;
    end
    else
    begin
      rx_sync_ff  <= {rx_sync_ff[1:0], serial_in};
      xr_sync_ff  <= {xr_sync_ff[1:0], external_reset};
      rx_lvl_d_ff <= rx_lvl_ff;
      if (rx_sync_ff[2] == rx_sync_ff[1])
        rx_lvl_ff <= rx_sync_ff[2];
      if (xr_sync_ff[2] == xr_sync_ff[1])
        xr_lvl_ff <= xr_sync_ff[2];
    end

  // power-on hold after hresetn release
  logic [PW-1:0] por_cnt_ff;
  logic          por_busy_ff;
  logic          soft_rst;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      por_cnt_ff  <= '0;
      por_busy_ff <= 1'b1;
    end
    else if (por_busy_ff)
    begin
      por_cnt_ff <= por_cnt_ff + PW'(1);
      if (por_cnt_ff == PW'(POR_CYCLES - 1))
        por_busy_ff <= 1'b0;
    end
  assign soft_rst = por_busy_ff | xr_lvl_ff;

  // bus front end; a read right after a write waits one cycle
  logic       wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic       accept;
  logic       rd_now;
  assign accept    = hsel & hready & htrans[1];
  assign rd_now    = accept & ~hwrite;
  assign hreadyout = ~(wr_pend_ff & hsel & htrans[1] & ~hwrite);
  assign hresp     = 1'b0;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end
    else
    begin
      wr_pend_ff <= accept & hwrite & (hsize == 3'h2);
      if (accept)
        wr_addr_ff <= haddr[7:0];
    end

  // software registers
  logic [7:0]  ier_ff;
  logic [7:0]  fcr_ff;
  logic [7:0]  lcr_ff;
  logic [7:0]  mcr_ff;
  logic [7:0]  efr_ff;
  logic [15:0] div_ff;
  logic        fifo_clr;
  logic        fifo_en;
  logic        dma_mode;
  logic        auto_rts;
  assign fifo_en  = fcr_ff[`URC_FCR_EN];
  assign dma_mode = fcr_ff[`URC_FCR_DMA];
  assign auto_rts = efr_ff[`URC_EFR_ARTS] & mcr_ff[`URC_MCR_RTS];
  // mode change or clear bit flushes stored characters
  assign fifo_clr = wr_pend_ff & (wr_addr_ff == `URC_A_FCR)
                    & (hwdata[`URC_FCR_CLR]
                       | (hwdata[`URC_FCR_EN] != fifo_en));
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ier_ff <= 8'h00;
      fcr_ff <= 8'h00;
      lcr_ff <= `URC_LCR_RST;
      mcr_ff <= 8'h00;
      efr_ff <= 8'h00;
      div_ff <= `URC_DIV_RST;
    end
    else if (soft_rst)
    begin
      ier_ff <= 8'h00;
      fcr_ff <= 8'h00;
      lcr_ff <= `URC_LCR_RST;
      mcr_ff <= 8'h00;
      efr_ff <= 8'h00;
      div_ff <= `URC_DIV_RST;
    end
    else if (wr_pend_ff)
      case (wr_addr_ff)
        `URC_A_IER: ier_ff <= hwdata[7:0];
        `URC_A_FCR: fcr_ff <= hwdata[7:0] & 8'hC9;
        `URC_A_LCR: lcr_ff <= hwdata[7:0];
        `URC_A_MCR: mcr_ff <= hwdata[7:0];
        `URC_A_EFR: efr_ff <= hwdata[7:0];
        `URC_A_DLL: div_ff[7:0] <= hwdata[7:0];
        `URC_A_DLH: div_ff[15:8] <= hwdata[7:0];
        default: ;
      endcase

  // divisor gives the 16x tick; zero behaves as one
  logic [15:0] div_cnt_ff;
  logic        tick_ff;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      div_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b0;
    end
    else if (soft_rst)
    begin
      div_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b0;
    end
    else if (({1'b0, div_cnt_ff} + 17'h00001) >= {1'b0, div_ff})
    begin
      div_cnt_ff <= 16'h0000;
      tick_ff    <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 16'h0001;
      tick_ff    <= 1'b0;
    end
  assign baud_clock_output = tick_ff;

  // receiver state machine
  urc_pkg::urc_rx_state_type st_ff;
  logic [3:0] os_ff;
  logic [2:0] bit_ff;
  logic [7:0] sh_ff;
  logic       par_ff;
  logic       ones_ff;
  logic       pe_ff;
  logic       push_ff;
  logic [7:0] pdata_ff;
  logic [2:0] perr_ff;
  logic [2:0] wl_last;
  assign wl_last = {1'b1, lcr_ff[1:0]}; // 5..8 bits, index of last
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      st_ff    <= urc_pkg::st_idle;
      os_ff    <= 4'h0;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      par_ff   <= 1'b0;
      ones_ff  <= 1'b0;
      pe_ff    <= 1'b0;
      push_ff  <= 1'b0;
      pdata_ff <= 8'h00;
      perr_ff  <= 3'h0;
    end
    else if (soft_rst)
    begin
      st_ff   <= urc_pkg::st_idle;
      os_ff   <= 4'h0;
      push_ff <= 1'b0;
    end
    else
    begin
      push_ff <= 1'b0;
      if (tick_ff && st_ff != urc_pkg::st_idle)
        os_ff <= os_ff + 4'h1;
      unique case (st_ff)
        urc_pkg::st_idle:
          if (rx_lvl_d_ff && !rx_lvl_ff)
          begin
            st_ff <= urc_pkg::st_start;
            os_ff <= 4'h0;
          end
        urc_pkg::st_start:
          if (tick_ff && os_ff == `URC_MID)
          begin
            // mid-start sample: high means a glitch
            st_ff   <= rx_lvl_ff ? urc_pkg::st_idle : urc_pkg::st_data;
            os_ff   <= 4'h0;
            bit_ff  <= 3'h0;
            par_ff  <= 1'b0;
            ones_ff <= 1'b0;
            pe_ff   <= 1'b0;
          end
        urc_pkg::st_data:
          if (tick_ff && os_ff == `URC_LAST)
          begin
            sh_ff   <= {rx_lvl_ff, sh_ff[7:1]};
            par_ff  <= par_ff ^ rx_lvl_ff;
            ones_ff <= ones_ff | rx_lvl_ff;
            bit_ff  <= bit_ff + 3'h1;
            if (bit_ff == wl_last)
              st_ff <= lcr_ff[`URC_LCR_PEN] ? urc_pkg::st_par
                                             : urc_pkg::st_stop;
          end
        urc_pkg::st_par:
          if (tick_ff && os_ff == `URC_LAST)
          begin
            pe_ff   <= par_ff ^ rx_lvl_ff ^ ~lcr_ff[`URC_LCR_EPS];
            ones_ff <= ones_ff | rx_lvl_ff;
            st_ff   <= urc_pkg::st_stop;
          end
        urc_pkg::st_stop:
          if (tick_ff && os_ff == `URC_LAST)
          begin
            // error field order: break, framing, parity
            push_ff  <= 1'b1;
            pdata_ff <= sh_ff >> (2'h3 - lcr_ff[1:0]);
            perr_ff  <= {~ones_ff & ~rx_lvl_ff, ~rx_lvl_ff, pe_ff};
            st_ff    <= urc_pkg::st_idle;
          end
        default: st_ff <= urc_pkg::st_idle;
      endcase
    end

  // receive fifo; non-fifo mode keeps one holding entry
  logic [10:0]   mem [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [CW-1:0] cnt_ff;
  logic [7:0]    cnt8;
  logic          room;
  logic          push_ok;
  logic          pop;
  logic          oe_ff;
  assign cnt8    = 8'(cnt_ff);
  assign room    = fifo_en ? (cnt_ff < CW'(DEPTH)) : (cnt_ff == '0);
  assign push_ok = push_ff & room;
  assign pop     = rd_now & (haddr[7:0] == `URC_A_RHR) & (cnt_ff != '0);
  always_ff @(posedge hclk)
    if (push_ok)
      mem[wp_ff] <= {perr_ff, pdata_ff};
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else if (soft_rst || fifo_clr)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push_ok)
        wp_ff <= wp_ff + AW'(1);
      if (pop)
        rp_ff <= rp_ff + AW'(1);
      cnt_ff <= cnt_ff + CW'(push_ok) - CW'(pop);
    end
  // overrun sticky; a new overrun beats the clearing read
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      oe_ff <= 1'b0;
    else if (soft_rst)
      oe_ff <= 1'b0;
    else if (push_ff && !room)
      oe_ff <= 1'b1;
    else if (rd_now && haddr[7:0] == `URC_A_LSR)
      oe_ff <= 1'b0;

  // trigger and flow thresholds picked by depth
  logic [1:0] tsel;
  logic [7:0] trig;
  logic [7:0] rts_off;
  logic [7:0] rts_on;
  logic       at_trig;
  assign tsel    = fcr_ff[`URC_FCR_TRG +: 2];
  assign trig    = (DEPTH == 64) ? 8'(`URC_TRG64 >> {tsel, 3'h0})
                                 : 8'(`URC_TRG16 >> {tsel, 3'h0});
  assign rts_off = (DEPTH == 64) ? 8'(`URC_OFF64 >> {tsel, 3'h0})
                                 : 8'(`URC_OFF16 >> {tsel, 3'h0});
  assign rts_on  = (DEPTH == 64) ? 8'(`URC_ON64 >> {tsel, 3'h0})
                                 : 8'(`URC_ON16 >> {tsel, 3'h0});
  assign at_trig = cnt8 >= trig;

  // character timeout counted in 16x ticks of the baud clock
  logic [11:0] to_cnt_ff;
  logic [11:0] to_lim;
  logic        to_ff;
  logic [3:0]  char_bits;
  assign char_bits = 4'h7 + {2'h0, lcr_ff[1:0]}
                     + {3'h0, lcr_ff[`URC_LCR_PEN]}
                     + {3'h0, lcr_ff[`URC_LCR_STB]};
  assign to_lim = 12'((`URC_TO_CHARS * char_bits + `URC_TO_BITS)
                      * `URC_OVS);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      to_cnt_ff <= 12'h000;
      to_ff     <= 1'b0;
    end
    else if (soft_rst || !fifo_en || cnt_ff == '0 || pop)
    begin
      to_cnt_ff <= 12'h000;
      to_ff     <= 1'b0;
    end
    else if (push_ok && !to_ff)
      to_cnt_ff <= 12'h000;
    else if (tick_ff && !to_ff)
    begin
      if (to_cnt_ff + 12'h001 >= to_lim)
        to_ff <= 1'b1;
      else
        to_cnt_ff <= to_cnt_ff + 12'h001;
    end

  // receive dma request
  logic burst_ff;
  logic dma_req;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      burst_ff <= 1'b0;
    else if (soft_rst || !(fifo_en && dma_mode))
      burst_ff <= 1'b0;
    else if (at_trig || to_ff)
      burst_ff <= 1'b1;
    else if (cnt_ff == '0)
      burst_ff <= 1'b0;
  assign dma_req = (fifo_en && dma_mode) ? burst_ff
                                         : (cnt_ff != '0);
  assign receive_dma_request_n = ~dma_req;

  // auto request-to-send with hysteresis
  logic rts_ff;
  logic nxt_rts;
  logic rts_int_ff;
  always_comb
  begin
    nxt_rts = mcr_ff[`URC_MCR_RTS];
    if (auto_rts)
    begin
      nxt_rts = rts_ff;
      if (cnt8 >= rts_off)
        nxt_rts = 1'b0;
      else if (cnt8 <= rts_on)
        nxt_rts = 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rts_ff <= 1'b0;
    else if (soft_rst)
      rts_ff <= 1'b0;
    else
      rts_ff <= nxt_rts;
  assign request_to_send_n = ~rts_ff;
  // pin 0 to 1 sets the flag; new event beats the clearing read
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rts_int_ff <= 1'b0;
    else if (soft_rst)
      rts_int_ff <= 1'b0;
    else if (efr_ff[`URC_EFR_ARTS] && ier_ff[`URC_IER_RTS]
             && rts_ff && !nxt_rts)
      rts_int_ff <= 1'b1;
    else if (rd_now && haddr[7:0] == `URC_A_IIR)
      rts_int_ff <= 1'b0;

  // interrupt sources and identification
  logic rx_int;
  logic [7:0] interrupt_identification;
  assign rx_int = ier_ff[`URC_IER_RX]
                  & (fifo_en ? at_trig : (cnt_ff != '0));
  assign interrupt_identification = {2'h0, rts_int_ff, 1'b0, to_ff & ier_ff[`URC_IER_RX],
                rx_int, 1'b0, ~interrupt_out};
  assign interrupt_out = rx_int | (to_ff & ier_ff[`URC_IER_RX]) | rts_int_ff;

  // read data registered at the address phase
  logic [31:0] rd_ff;
  logic [10:0] head;
  assign head = mem[rp_ff];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_ff <= 32'h0000_0000;
    else if (rd_now)
      case (haddr[7:0])
        `URC_A_RHR: rd_ff <= {24'h0, (cnt_ff != '0) ? head[7:0] : 8'h00};
        `URC_A_IER: rd_ff <= {24'h0, ier_ff};
        `URC_A_IIR: rd_ff <= {24'h0, interrupt_identification};
        `URC_A_FCR: rd_ff <= {24'h0, fcr_ff};
        `URC_A_LCR: rd_ff <= {24'h0, lcr_ff};
        `URC_A_MCR: rd_ff <= {24'h0, mcr_ff};
        `URC_A_LSR: rd_ff <= {24'h0, 3'h0,
                              (cnt_ff != '0) ? head[10:8] : 3'h0,
                              oe_ff, cnt_ff != '0};
        `URC_A_DLL: rd_ff <= {24'h0, div_ff[7:0]};
        `URC_A_DLH: rd_ff <= {24'h0, div_ff[15:8]};
        `URC_A_EFR: rd_ff <= {24'h0, efr_ff};
        default:    rd_ff <= 32'h0000_0000;
      endcase
  assign hrdata = rd_ff;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_TICK_DIV3: assert property ((tick_ff && div_ff == 16'h0003 && !wr_pend_ff) |=> !tick_ff [*2] ##1 tick_ff) else $error("tick spacing wrong");
  AST_POR_HOLD: assert property (por_busy_ff |=> cnt_ff == '0 && st_ff == urc_pkg::st_idle) else $error("not held in reset");
  AST_START_REJECT: assert property ((st_ff == urc_pkg::st_start && tick_ff && os_ff == `URC_MID && rx_lvl_ff && !soft_rst) |=> st_ff == urc_pkg::st_idle) else $error("high start accepted");
  AST_PUSH_COUNT: assert property ((push_ok && !pop && !fifo_clr && !soft_rst) |=> cnt_ff == $past(cnt_ff) + CW'(1)) else $error("push lost");
  AST_FIFO_INT: assert property ((fifo_en && at_trig && ier_ff[`URC_IER_RX]) |-> interrupt_out && interrupt_identification[2]) else $error("trigger int missing");
  AST_TO_CLEAR: assert property ((to_ff && pop) |=> !to_ff) else $error("timeout not cleared");
  AST_BURST_HOLD: assert property ((burst_ff && cnt_ff > CW'(1) && !soft_rst && !fifo_clr && !wr_pend_ff && fifo_en && dma_mode) |=> !receive_dma_request_n) else $error("dma burst dropped");
  AST_MODE0_DMA: assert property ((!fifo_en && pop && !push_ok && !soft_rst) |=> receive_dma_request_n) else $error("dma request stuck");
  AST_RTS_OFF: assert property ((auto_rts && cnt8 >= rts_off && !soft_rst) |=> request_to_send_n) else $error("rts not deasserted");
  AST_RTS_INT: assert property ($rose(request_to_send_n) && $past(efr_ff[`URC_EFR_ARTS] && ier_ff[`URC_IER_RTS] && !soft_rst) |-> rts_int_ff && interrupt_out) else $error("rts int missing");
endmodule
`default_nettype wire

// file: testbench/urc_serial_source.sv
// remote serial transmitter model driving the receive line
`default_nettype none
module urc_serial_source
(
  // clock
  input  wire logic hclk,
  // line
  output var  logic serial_line
);
  timeunit 1ns;
  timeprecision 1ps;

  int   bit_clocks = 16;        // 16x ticks per bit, times the divisor
  logic parity_on  = 1'b0;      // even parity bit after the data

  // line rests high between frames, so no false start edge
  initial serial_line = 1'b1;

  // one frame, lsb first; bad_par flips parity, bad_stop sends stop low
  task automatic send(input logic [7:0] data, input logic bad_par,
                      input logic bad_stop);
    logic [10:0] frame;
    frame = {~bad_stop, (^data) ^ bad_par, data, 1'b0};
    @(posedge hclk);
    for (int i = 0; i < 11; i++)
    begin
      if (i != 9 || parity_on)
      begin
        serial_line <= frame[i];
        repeat (bit_clocks) @(posedge hclk);
      end
    end
    serial_line <= 1'b1;
  endtask

  // short low pulse; must die at the mid-start sample
  task automatic glitch(input int clocks);
    @(posedge hclk);
    serial_line <= 1'b0;
    repeat (clocks) @(posedge hclk);
    serial_line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: testbench/urc_receive_channel_bench.sv
// bench for the receive channel: bus tasks and directed tests
`default_nettype none
`include "urc_consts.svh"
module urc_receive_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int POR = 16;

  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        serial_in, external_reset, request_to_send_n;
  logic        receive_dma_request_n, baud_clock_output, interrupt_out;
  int          num_errors, check_count, pulses;
  logic [7:0]  ra [8] = '{`URC_A_LCR, `URC_A_IER, `URC_A_IIR, `URC_A_LSR,
                          `URC_A_DLL, `URC_A_DLH, `URC_A_MCR, 8'h28};
  logic [7:0]  re [8] = '{8'h03, 8'h00, 8'h01, 8'h00,
                          8'h01, 8'h00, 8'h00, 8'h00};

  assign hready = hreadyout;

  urc_receive_channel #(.DEPTH(16), .POR_CYCLES(POR)) urc_receive_channel_inst
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .serial_in(serial_in), .external_reset(external_reset),
    .request_to_send_n(request_to_send_n),
    .receive_dma_request_n(receive_dma_request_n),
    .baud_clock_output(baud_clock_output), .interrupt_out(interrupt_out)
  );

  urc_serial_source urc_serial_source_inst
  (
    .hclk(hclk),
    .serial_line(serial_in)
  );

  // 100 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // look at ready just before the edge, where it has settled
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge hclk);
    end
    if (n == 50)
    begin
      num_errors++;
      summarize();
    end
    @(posedge hclk);
  endtask

  // one single word transfer, address phase held until ready
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
    @(negedge hclk); // flops launched at that edge settle first
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, 8'h00);
    check(rd & m, exp);
  endtask

  // frame then room for the 3-stage sync and the push
  task automatic sendc(input logic [7:0] d, input logic bp = 1'b0,
                       input logic bs = 1'b0);
    urc_serial_source_inst.send(d, bp, bs);
    repeat (8) @(posedge hclk);
  endtask

  // hang guard
  initial
  begin
    repeat (100000) @(posedge hclk);
    num_errors++;
    summarize();
  end

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    external_reset = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, `URC_A_LCR, 8'h1B); // lands inside the power-on hold
    repeat (POR + 4) @(posedge hclk);
    for (int i = 0; i < 8; i++)
      rdc(ra[i], {24'h000000, re[i]});
    check({31'h0, request_to_send_n}, 32'h1);
    check({31'h0, receive_dma_request_n}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    $display("test reset done");

    // divisor 3: one tick per three clocks, bits 48 clocks
    bus(1'b1, `URC_A_DLL, 8'h03);
    bus(1'b1, `URC_A_DLH, 8'h00);
    pulses = 0;
    repeat (48)
    begin
      @(negedge hclk);
      pulses += int'(baud_clock_output === 1'b1);
    end
    check(pulses, 16);
    urc_serial_source_inst.bit_clocks = 48;
    bus(1'b1, `URC_A_IER, 8'h01);
    sendc(8'hA5);
    check({31'h0, interrupt_out}, 32'h1);
    check({31'h0, receive_dma_request_n}, 32'h0);
    rdc(`URC_A_IIR, 32'h04);
    rdc(`URC_A_LSR, 32'h01);
    rdc(`URC_A_RHR, 32'hA5);
    check({31'h0, interrupt_out}, 32'h0);
    check({31'h0, receive_dma_request_n}, 32'h1);
    rdc(`URC_A_LSR, 32'h00);
    bus(1'b1, `URC_A_DLL, 8'h01);
    urc_serial_source_inst.bit_clocks = 16;
    $display("test non-fifo done");

    // fifo, dma, trigger 4, even parity, second char corrupted
    bus(1'b1, `URC_A_LCR, 8'h1B);
    urc_serial_source_inst.parity_on = 1'b1;
    bus(1'b1, `URC_A_FCR, 8'h49);
    sendc(8'h11);
    sendc(8'h22, 1'b1);
    sendc(8'h33);
    check({31'h0, interrupt_out}, 32'h0);
    check({31'h0, receive_dma_request_n}, 32'h1);
    sendc(8'h44);
    check({31'h0, interrupt_out}, 32'h1);
    check({31'h0, receive_dma_request_n}, 32'h0);
    rdc(`URC_A_RHR, 32'h11);
    check({31'h0, interrupt_out}, 32'h0);
    check({31'h0, receive_dma_request_n}, 32'h0);
    rdc(`URC_A_LSR, 32'h05);
    rdc(`URC_A_RHR, 32'h22);
    rdc(`URC_A_RHR, 32'h33);
    rdc(`URC_A_RHR, 32'h44);
    check({31'h0, receive_dma_request_n}, 32'h1);
    rdc(`URC_A_LSR, 32'h00);
    urc_serial_source_inst.glitch(4);
    repeat (200) @(posedge hclk);
    rdc(`URC_A_LSR, 32'h00);
    sendc(8'h55, 1'b0, 1'b1);
    rdc(`URC_A_LSR, 32'h09);
    rdc(`URC_A_RHR, 32'h55);
    $display("test fifo done");

    // timeout: 11-bit chars give (4*11+12)*16 = 896 clocks
    sendc(8'h66);
    repeat (800) @(posedge hclk);
    check({31'h0, interrupt_out}, 32'h0);
    pulses = 0;
    while (interrupt_out !== 1'b1 && pulses < 200)
    begin
      pulses++;
      @(negedge hclk);
    end
    check({31'h0, interrupt_out}, 32'h1);
    if (interrupt_out !== 1'b1)
      summarize();
    // request follows the timeout flag one clock later
    @(negedge hclk);
    check({31'h0, receive_dma_request_n}, 32'h0);
    rdc(`URC_A_IIR, 32'h08, 32'h08);
    rdc(`URC_A_RHR, 32'h66);
    check({31'h0, interrupt_out}, 32'h0);
    $display("test timeout done");

    // auto rts, trigger 1: off at 2, back on at 0
    bus(1'b1, `URC_A_FCR, 8'h01);
    bus(1'b1, `URC_A_EFR, 8'h40);
    bus(1'b1, `URC_A_IER, 8'h41);
    bus(1'b1, `URC_A_MCR, 8'h02);
    @(negedge hclk); // pin flop follows the register one clock later
    check({31'h0, request_to_send_n}, 32'h0);
    sendc(8'h77);
    check({31'h0, request_to_send_n}, 32'h0);
    sendc(8'h88);
    check({31'h0, request_to_send_n}, 32'h1);
    rdc(`URC_A_IIR, 32'h20, 32'h20);
    rdc(`URC_A_RHR, 32'h77);
    check({31'h0, request_to_send_n}, 32'h1);
    rdc(`URC_A_RHR, 32'h88);
    check({31'h0, request_to_send_n}, 32'h0);
    $display("test auto rts done");

    // external reset pin returns the default state
    @(posedge hclk);
    external_reset <= 1'b1;
    repeat (8) @(posedge hclk);
    external_reset <= 1'b0;
    repeat (POR + 10) @(posedge hclk);
    check({31'h0, request_to_send_n}, 32'h1);
    rdc(`URC_A_MCR, 32'h00);
    rdc(`URC_A_LCR, 32'h03);
    $display("test external reset done");
    summarize();
  end
endmodule
`default_nettype wire
